// file: hdl/sar_port_pkg.sv
package sar_port_pkg;

   // ----------------------------------------------------------------
   // widths and buffering
   // ----------------------------------------------------------------
   localparam int RESULT_W   = 16;
   localparam int FIFO_DEPTH = 8;
   localparam int TICK_W     = 9;
   localparam int BIT_W      = 5;

   // ----------------------------------------------------------------
   // clocking
   // ----------------------------------------------------------------
   localparam int CLK_MHZ      = 40;
   localparam int CONVERT_STROBE_N_CLK_DIV = 2;
   localparam int CONVERT_STROBE_N_CLK_MHZ = CLK_MHZ / CONVERT_STROBE_N_CLK_DIV;

   // ----------------------------------------------------------------
   // times in ns, counts in conversion clock ticks
   // ----------------------------------------------------------------
   localparam int CONVERT_STROBE_N_TIME_NS   = 18000;
   localparam int SCLK_HALF_NS   = 410;
   localparam int FIRST_EDGE_NS  = 2000;

   localparam logic [TICK_W-1:0] CONVERT_STROBE_N_TICKS =
      TICK_W'((CONVERT_STROBE_N_TIME_NS * CONVERT_STROBE_N_CLK_MHZ) / 1000);
   localparam logic [TICK_W-1:0] SCLK_HALF_TICKS =
      TICK_W'((SCLK_HALF_NS * CONVERT_STROBE_N_CLK_MHZ) / 1000);
   localparam logic [TICK_W-1:0] SCLK_SHIFT_TICK =
      TICK_W'((SCLK_HALF_NS * CONVERT_STROBE_N_CLK_MHZ) / 2000);
   localparam logic [TICK_W-1:0] FIRST_EDGE_TICKS =
      TICK_W'((FIRST_EDGE_NS * CONVERT_STROBE_N_CLK_MHZ) / 1000);
   localparam logic [BIT_W-1:0]  LAST_BIT = BIT_W'(RESULT_W - 1);
   localparam logic [BIT_W-1:0]  ALL_BITS = BIT_W'(RESULT_W);

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [RESULT_W-1:0] RESULT_RST = 16'h0000;
   localparam logic                BUSY_N_RST = 1'b1;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CONVERT,
      ST_FINISH
   } convert_strobe_n_state_t;

   typedef struct packed {
      logic data;
      logic data_oe;
      logic busy_n;
      logic busy_n_oe;
      logic sclk;
      logic sclk_oe;
   } pin_out_t;

endpackage : sar_port_pkg

// file: hdl/sar_conversion_port.sv
`timescale 1ns/1ps

// ------------------------------------------------------------------
// result buffer
// ------------------------------------------------------------------
module result_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             ref_clk_i,
   input  wire logic             rst_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   logic [AW:0]      count_nxt;
   logic             push;
   logic             pop;

   assign push = in_valid_i && in_ready_o;
   assign pop  = out_valid_o && out_ready_i;
   assign out_data_o = mem[rd_ptr_r];

   always_comb begin
      count_nxt = count_r;
      if (push && !pop) begin
         count_nxt = count_r + (AW+1)'(1);
      end else if (pop && !push) begin
         count_nxt = count_r - (AW+1)'(1);
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data_i;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + AW'(1);
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + AW'(1);
         end
      end
   end

   // flags are registered so that ready and valid come straight from flops
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         count_r     <= '0;
         in_ready_o  <= 1'b1;
         out_valid_o <= 1'b0;
      end else begin
         count_r     <= count_nxt;
         in_ready_o  <= (count_nxt != (AW+1)'(DEPTH));
         out_valid_o <= (count_nxt != '0);
      end
   end

endmodule : result_fifo

// ------------------------------------------------------------------
// conversion control and serial result port
// ------------------------------------------------------------------
module sar_conversion_port
   import sar_port_pkg::*;
(
   input  wire logic                ref_clk_i,
   input  wire logic                rst_i,
   input  wire logic                convert_strobe_n_i,
   input  wire logic                cs_n_i,
   input  wire logic                clock_source_select_i,
   input  wire logic                power_down_request_i,
   input  wire logic                serial_bit_clock_i,
   input  wire logic                result_valid_i,
   input  wire logic [RESULT_W-1:0] result_data_i,
   output logic                     result_ready_o,
   output logic                     sample_hold_o,
   output logic                     low_power_o,
   output logic                     busy_n_o,
   output logic                     busy_n_oe_o,
   output logic                     serial_data_o,
   output logic                     serial_data_oe_o,
   output logic                     serial_bit_clock_o,
   output logic                     serial_bit_clock_oe_o
);

   convert_strobe_n_state_t         state_r;
   logic                strobe_prev_r;
   logic                strobe_fall;
   logic [$clog2(CONVERT_STROBE_N_CLK_DIV)-1:0] div_cnt_r;
   logic                convert_strobe_n_tick;
   logic [TICK_W-1:0]   convert_strobe_n_cnt_r;
   logic                busy_n_r;
   logic                fifo_valid;
   logic                fifo_pop;
   logic [RESULT_W-1:0] fifo_data;
   logic [RESULT_W-1:0] shift_r;
   logic                int_start;
   logic                ser_active_r;
   logic                ser_lead_r;
   logic                sclk_r;
   logic [TICK_W-1:0]   ser_cnt_r;
   logic [BIT_W-1:0]    bit_cnt_r;
   logic                int_shift;
   logic                ext_prev_r;
   logic                ext_rise;
   logic [BIT_W-1:0]    ext_cnt_r;
   pin_out_t            pins_r;

   // ----------------------------------------------------------------
   // strobe edge and conversion clock
   // ----------------------------------------------------------------
   assign strobe_fall = strobe_prev_r && !convert_strobe_n_i;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         strobe_prev_r <= 1'b1;
      end else begin
         strobe_prev_r <= convert_strobe_n_i;
      end
   end

   // the divider halts in power-down, so nothing downstream toggles then
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || low_power_o) begin
         div_cnt_r <= '0;
      end else if (div_cnt_r == ($clog2(CONVERT_STROBE_N_CLK_DIV))'(CONVERT_STROBE_N_CLK_DIV-1)) begin
         div_cnt_r <= '0;
      end else begin
         div_cnt_r <= div_cnt_r + ($clog2(CONVERT_STROBE_N_CLK_DIV))'(1);
      end
   end

   assign convert_strobe_n_tick = !low_power_o &&
                      (div_cnt_r == ($clog2(CONVERT_STROBE_N_CLK_DIV))'(CONVERT_STROBE_N_CLK_DIV-1));

   // follows the request directly; the strobe level plays no part
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         low_power_o <= 1'b0;
      end else begin
         low_power_o <= power_down_request_i;
      end
   end

   // ----------------------------------------------------------------
   // conversion sequence
   // ----------------------------------------------------------------
   assign fifo_pop  = (state_r == ST_FINISH) && fifo_valid;
   assign int_start = (state_r == ST_IDLE) && strobe_fall && !low_power_o
                      && !clock_source_select_i;

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         state_r    <= ST_IDLE;
         convert_strobe_n_cnt_r <= '0;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (strobe_fall && !low_power_o) begin
                  state_r    <= ST_CONVERT;
                  convert_strobe_n_cnt_r <= '0;
               end
            end
            ST_CONVERT: begin
               // strobe edges are not looked at here
               if (convert_strobe_n_tick) begin
                  if (convert_strobe_n_cnt_r == CONVERT_STROBE_N_TICKS - TICK_W'(1)) begin
                     state_r <= ST_FINISH;
                  end else begin
                     convert_strobe_n_cnt_r <= convert_strobe_n_cnt_r + TICK_W'(1);
                  end
               end
            end
            ST_FINISH: begin
               // waits for the converter core's word; stalls if none queued
               if (fifo_valid) begin
                  state_r <= ST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         busy_n_r <= BUSY_N_RST;
      end else if (state_r == ST_IDLE && strobe_fall && !low_power_o) begin
         busy_n_r <= 1'b0;
      end else if (fifo_pop) begin
         busy_n_r <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         sample_hold_o <= 1'b0;
      end else begin
         sample_hold_o <= (state_r == ST_IDLE && strobe_fall && !low_power_o)
                          || (state_r != ST_IDLE && !fifo_pop);
      end
   end

   result_fifo #(
      .WIDTH (RESULT_W),
      .DEPTH (FIFO_DEPTH)
   ) u_result_fifo (
      .ref_clk_i   (ref_clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (result_valid_i),
      .in_ready_o  (result_ready_o),
      .in_data_i   (result_data_i),
      .out_valid_o (fifo_valid),
      .out_ready_i (state_r == ST_FINISH),
      .out_data_o  (fifo_data)
   );

   // ----------------------------------------------------------------
   // internal serial bit clock
   // ----------------------------------------------------------------
   // whole transfer fits inside the conversion, so busy frames it
   assign int_shift = ser_active_r && !ser_lead_r && !sclk_r && convert_strobe_n_tick
                      && (ser_cnt_r == SCLK_SHIFT_TICK - TICK_W'(1));

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ser_active_r <= 1'b0;
         ser_lead_r   <= 1'b0;
         sclk_r       <= 1'b0;
         ser_cnt_r    <= '0;
         bit_cnt_r    <= '0;
      end else if (int_start) begin
         ser_active_r <= 1'b1;
         ser_lead_r   <= 1'b1;
         sclk_r       <= 1'b0;
         ser_cnt_r    <= '0;
         bit_cnt_r    <= '0;
      end else if (clock_source_select_i) begin
         ser_active_r <= 1'b0;
         sclk_r       <= 1'b0;
      end else if (ser_active_r && convert_strobe_n_tick) begin
         ser_cnt_r <= ser_cnt_r + TICK_W'(1);
         if (ser_lead_r) begin
            if (ser_cnt_r == FIRST_EDGE_TICKS - TICK_W'(1)) begin
               ser_lead_r <= 1'b0;
               sclk_r     <= 1'b1;
               ser_cnt_r  <= '0;
            end
         end else if (ser_cnt_r == SCLK_HALF_TICKS - TICK_W'(1)) begin
            ser_cnt_r <= '0;
            if (sclk_r) begin
               sclk_r <= 1'b0;
               if (bit_cnt_r == LAST_BIT) begin
                  ser_active_r <= 1'b0;
               end
            end else begin
               sclk_r <= 1'b1;
            end
         end
         if (int_shift) begin
            bit_cnt_r <= bit_cnt_r + BIT_W'(1);
         end
      end
   end

   // ----------------------------------------------------------------
   // external serial bit clock
   // ----------------------------------------------------------------
   // each of the first 16 host rising edges after a result is loaded moves the next bit onto the data pin
   assign ext_rise = clock_source_select_i && serial_bit_clock_i && !ext_prev_r
                     && (ext_cnt_r != ALL_BITS);

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ext_prev_r <= 1'b0;
      end else begin
         ext_prev_r <= serial_bit_clock_i;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i || fifo_pop) begin
         ext_cnt_r <= '0;
      end else if (ext_rise) begin
         ext_cnt_r <= ext_cnt_r + BIT_W'(1);
      end
   end

   // ----------------------------------------------------------------
   // output shift register
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         shift_r <= RESULT_RST;
      end else if (fifo_pop) begin
         shift_r <= fifo_data;
      end else if (int_start) begin
         shift_r <= shift_r;
      end else if (int_shift || ext_rise) begin
         shift_r <= {shift_r[RESULT_W-2:0], 1'b0};
      end
   end

   // ----------------------------------------------------------------
   // pins
   // ----------------------------------------------------------------
   // enables follow chip select, the clock enable also needs the internal clock selected; conversions run regardless
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         pins_r <= '{data: 1'b0, data_oe: 1'b0, busy_n: BUSY_N_RST,
                     busy_n_oe: 1'b0, sclk: 1'b0, sclk_oe: 1'b0};
      end else begin
         pins_r.data      <= shift_r[RESULT_W-1];
         pins_r.data_oe   <= !cs_n_i;
         pins_r.busy_n    <= busy_n_r;
         pins_r.busy_n_oe <= !cs_n_i;
         pins_r.sclk      <= sclk_r;
         pins_r.sclk_oe   <= !cs_n_i && !clock_source_select_i;
      end
   end

   assign serial_data_o         = pins_r.data;
   assign serial_data_oe_o      = pins_r.data_oe;
   assign busy_n_o              = pins_r.busy_n;
   assign busy_n_oe_o           = pins_r.busy_n_oe;
   assign serial_bit_clock_o    = pins_r.sclk;
   assign serial_bit_clock_oe_o = pins_r.sclk_oe;

endmodule : sar_conversion_port

// file: test/sar_port_asserts.sv
`timescale 1ns/1ps
// ------------------------------------------------
// port checker
// ------------------------------------------------
module sar_port_asserts
   import sar_port_pkg::*;
(
   input wire logic                ref_clk_i,
   input wire logic                rst_i,
   input wire logic                convert_strobe_n_i,
   input wire logic                cs_n_i,
   input wire logic                clock_source_select_i,
   input wire logic                power_down_request_i,
   input wire logic                serial_bit_clock_i,
   input wire logic                result_valid_i,
   input wire logic [RESULT_W-1:0] result_data_i,
   input wire logic                result_ready_o,
   input wire logic                sample_hold_o,
   input wire logic                low_power_o,
   input wire logic                busy_n_o,
   input wire logic                busy_n_oe_o,
   input wire logic                serial_data_o,
   input wire logic                serial_data_oe_o,
   input wire logic                serial_bit_clock_o,
   input wire logic                serial_bit_clock_oe_o
);
   // lower bound only: an empty buffer or power-down may stretch a conversion
   localparam int CONVERT_STROBE_N_MIN = 700;
   logic [15:0] hold_cnt;
   logic [4:0]  rise_cnt;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   always_ff @(posedge ref_clk_i) begin
      if (rst_i || !sample_hold_o) hold_cnt <= '0;
      else hold_cnt <= hold_cnt + 16'h0001;
   end
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || $fell(busy_n_o)) rise_cnt <= '0;
      else if ($rose(serial_bit_clock_o)) rise_cnt <= rise_cnt + 5'h01;
   end

   sequence s_start_req;
      busy_n_o && !sample_hold_o && !low_power_o && $past(convert_strobe_n_i)
         && !convert_strobe_n_i;
   endsequence
   sequence s_high16;
      serial_bit_clock_o [*8] ##1 serial_bit_clock_o [*8];
   endsequence

   a_start_hold: assert property (s_start_req |=> sample_hold_o ##1 !busy_n_o)
      else $error("strobe edge did not start a conversion");
   a_busy_end: assert property ($fell(sample_hold_o) |-> !busy_n_o ##1 busy_n_o)
      else $error("busy did not rise right after conversion end");
   a_convert_strobe_n_length: assert property ($fell(sample_hold_o) |-> hold_cnt >= 16'(CONVERT_STROBE_N_MIN))
      else $error("conversion shorter than its internal timing");
   a_outputs_float: assert property (cs_n_i && !$past(rst_i) |=>
      !busy_n_oe_o && !serial_data_oe_o && !serial_bit_clock_oe_o)
      else $error("output driven while deselected");
   a_outputs_drive: assert property (!cs_n_i && !clock_source_select_i && !$past(rst_i) |=>
      busy_n_oe_o && serial_data_oe_o && serial_bit_clock_oe_o)
      else $error("output not driven while selected");
   a_ext_no_drive: assert property (clock_source_select_i && !$past(rst_i) |=>
      !serial_bit_clock_oe_o)
      else $error("bit clock driven in external mode");
   a_bit_stable: assert property ($rose(serial_bit_clock_o) && !clock_source_select_i |->
      $stable(serial_data_o) throughout (s_high16 ##1 !serial_bit_clock_o))
      else $error("data bit moved around a bit clock pulse");
   a_frame_bits: assert property ($rose(busy_n_o) && !clock_source_select_i |->
      rise_cnt == 5'h10)
      else $error("internal frame not sixteen bits within busy");
   a_pd_no_start: assert property (low_power_o && !sample_hold_o |=> !sample_hold_o)
      else $error("conversion started in power-down");
endmodule : sar_port_asserts

bind sar_conversion_port sar_port_asserts u_asserts (
   .ref_clk_i             (ref_clk_i),
   .rst_i                 (rst_i),
   .convert_strobe_n_i    (convert_strobe_n_i),
   .cs_n_i                (cs_n_i),
   .clock_source_select_i (clock_source_select_i),
   .power_down_request_i  (power_down_request_i),
   .serial_bit_clock_i    (serial_bit_clock_i),
   .result_valid_i        (result_valid_i),
   .result_data_i         (result_data_i),
   .result_ready_o        (result_ready_o),
   .sample_hold_o         (sample_hold_o),
   .low_power_o           (low_power_o),
   .busy_n_o              (busy_n_o),
   .busy_n_oe_o           (busy_n_oe_o),
   .serial_data_o         (serial_data_o),
   .serial_data_oe_o      (serial_data_oe_o),
   .serial_bit_clock_o    (serial_bit_clock_o),
   .serial_bit_clock_oe_o (serial_bit_clock_oe_o)
);

// file: test/host_reader.sv
`timescale 1ns/1ps
// ------------------------------------------------
// host side: captures words, makes the external clock
// ------------------------------------------------
module host_reader
   import sar_port_pkg::*;
(
   input  wire logic                ref_clk_i,
   input  wire logic                clear_i,
   input  wire logic                go_i,
   input  wire logic                sclk_pin_i,
   input  wire logic                data_pin_i,
   input  wire logic [3:0]          half_i,
   output logic                     host_sclk_o,
   output logic [RESULT_W-1:0]      word_o,
   output logic [BIT_W-1:0]         bits_o
);
   logic sclk_q;

   // bits taken at the sampled rising edge in both modes, msb ends on top
   always @(posedge ref_clk_i) begin
      sclk_q <= sclk_pin_i;
      if (clear_i) begin
         word_o <= '0;
         bits_o <= '0;
      end else if (sclk_pin_i && !sclk_q) begin
         word_o <= {word_o[RESULT_W-2:0], data_pin_i};
         bits_o <= bits_o + 5'h01;
      end
   end

   // clock stands low outside a read; half_i picks a prompt or slow pace
   initial begin
      host_sclk_o = 1'b0;
      forever begin
         @(posedge go_i);
         repeat (RESULT_W) begin
            repeat (half_i) @(negedge ref_clk_i);
            host_sclk_o = 1'b1;
            repeat (half_i) @(negedge ref_clk_i);
            host_sclk_o = 1'b0;
         end
      end
   end
endmodule : host_reader

// file: test/tb_top.sv
`timescale 1ns/1ps
module tb_top
   import sar_port_pkg::*;
;
   // ------------------------------------------------
   // stimulus and wiring
   // ------------------------------------------------
   logic                ref_clk_i             = 1'b0;
   logic                rst_i                 = 1'b1;
   logic                convert_strobe_n_i    = 1'b1;
   logic                cs_n_i                = 1'b0;
   logic                clock_source_select_i = 1'b0;
   logic                power_down_request_i  = 1'b0;
   logic                result_valid_i        = 1'b0;
   logic [RESULT_W-1:0] result_data_i         = 16'h0000;
   logic                result_ready_o, sample_hold_o, low_power_o, busy_n_o, busy_n_oe_o;
   logic                serial_data_o, serial_data_oe_o, serial_bit_clock_o, serial_bit_clock_oe_o;
   logic                go = 1'b0, clear = 1'b1, idle_tog = 1'b0, host_sclk;
   logic [3:0]          half = 4'h2;
   logic [RESULT_W-1:0] host_word;
   logic [BIT_W-1:0]    host_bits;
   int                  error_cnt = 0, n_tests = 0, cnt = 0, low_cnt = 0;
   logic [RESULT_W-1:0] words [8] = '{16'hA5C3, 16'h8000, 16'h7FFF, 16'h0001,
                                      16'hFFFF, 16'h1234, 16'hC0DE, 16'h4B2D};
   // cs_n, select, power-down | busy, data, clock enables, low power
   logic [6:0]          rows [4] = '{7'h0E, 7'h40, 7'h2C, 7'h71};
   // released lines do not keep their last level: they toggle every cycle
   wire serial_bit_clock_i = serial_bit_clock_oe_o ? serial_bit_clock_o :
                             clock_source_select_i ? host_sclk : idle_tog;
   wire data_pin = serial_data_oe_o ? serial_data_o : idle_tog;

   always #12.5 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) idle_tog <= ~idle_tog;
   always @(posedge ref_clk_i) if (busy_n_o === 1'b0) low_cnt <= low_cnt + 1;

   sar_conversion_port dut (
      .ref_clk_i             (ref_clk_i),
      .rst_i                 (rst_i),
      .convert_strobe_n_i    (convert_strobe_n_i),
      .cs_n_i                (cs_n_i),
      .clock_source_select_i (clock_source_select_i),
      .power_down_request_i  (power_down_request_i),
      .serial_bit_clock_i    (serial_bit_clock_i),
      .result_valid_i        (result_valid_i),
      .result_data_i         (result_data_i),
      .result_ready_o        (result_ready_o),
      .sample_hold_o         (sample_hold_o),
      .low_power_o           (low_power_o),
      .busy_n_o              (busy_n_o),
      .busy_n_oe_o           (busy_n_oe_o),
      .serial_data_o         (serial_data_o),
      .serial_data_oe_o      (serial_data_oe_o),
      .serial_bit_clock_o    (serial_bit_clock_o),
      .serial_bit_clock_oe_o (serial_bit_clock_oe_o)
   );
   host_reader u_host (
      .ref_clk_i   (ref_clk_i),
      .clear_i     (clear),
      .go_i        (go),
      .sclk_pin_i  (serial_bit_clock_i),
      .data_pin_i  (data_pin),
      .half_i      (half),
      .host_sclk_o (host_sclk),
      .word_o      (host_word),
      .bits_o      (host_bits)
   );

   // ------------------------------------------------
   // helpers
   // ------------------------------------------------
   task automatic chk(input string what, input logic [RESULT_W-1:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : give_verdict
   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask : tick
   task automatic start();
      low_cnt = 0;
      convert_strobe_n_i = 1'b0;
      tick(3);
   endtask : start
   task automatic push(input logic [RESULT_W-1:0] w);
      result_valid_i = 1'b1;
      result_data_i = w;
      tick(1);
      result_valid_i = 1'b0;
   endtask : push
   task automatic wait_busy(input int lim);
      for (cnt = 0; busy_n_o !== 1'b1; cnt++) begin
         if (cnt > lim) begin
            chk("busy wait", 1'b0, 1'b1);
            give_verdict();
         end
         tick(1);
      end
   endtask : wait_busy

   // ------------------------------------------------
   // main sequence
   // ------------------------------------------------
   initial begin
      tick(6);
      chk("reset outputs", {busy_n_o, busy_n_oe_o, serial_data_oe_o, serial_bit_clock_oe_o,
          result_ready_o, sample_hold_o, low_power_o}, 7'h44);
      rst_i = 1'b0;
      tick(1);
      foreach (rows[i]) begin
         {cs_n_i, clock_source_select_i, power_down_request_i} = rows[i][6:4];
         tick(2);
         chk("enables", {busy_n_oe_o, serial_data_oe_o, serial_bit_clock_oe_o, low_power_o},
             rows[i][3:0]);
      end
      {cs_n_i, clock_source_select_i, power_down_request_i} = 3'b000;
      tick(2);
      $display("enable table done");
      // the ninth word must be refused and never come out
      result_valid_i = 1'b1;
      for (int i = 0; i < 9; i++) begin
         result_data_i = (i < 8) ? words[i] : 16'h0F0F;
         tick(1);
      end
      result_valid_i = 1'b0;
      tick(2);
      chk("buffer full", result_ready_o, 1'b0);
      $display("buffer fill done");
      for (int k = 0; k < 8; k++) begin
         cs_n_i = (k == 1);
         clear = 1'b1;
         start();
         chk("started", {sample_hold_o, busy_n_o}, 2'b10);
         chk("busy float", busy_n_oe_o, k != 1);
         tick(10);
         cs_n_i = 1'b0;
         tick(3);
         clear = 1'b0;
         tick(300);
         convert_strobe_n_i = 1'b1;
         tick(2);
         convert_strobe_n_i = 1'b0;
         wait_busy(1000);
         chk("busy length", low_cnt inside {[710:735]}, 1'b1);
         chk("previous result", host_word, (k == 0) ? RESULT_RST : words[k-1]);
         chk("internal bits", host_bits, ALL_BITS);
         convert_strobe_n_i = 1'b1;
         tick(300);
      end
      chk("buffer drained", result_ready_o, 1'b1);
      $display("internal clock conversions done");
      clock_source_select_i = 1'b1;
      for (int j = 0; j < 2; j++) begin
         clear = 1'b1;
         start();
         tick(800);
         chk("stall on empty buffer", busy_n_o, 1'b0);
         push(~words[j]);
         wait_busy(50);
         convert_strobe_n_i = 1'b1;
         clear = 1'b0;
         half = j ? 4'h5 : 4'h2;
         go = 1'b1;
         tick(1);
         go = 1'b0;
         for (cnt = 0; host_bits !== ALL_BITS && cnt < 400; cnt++) tick(1);
         tick(12);
         chk("external word", host_word, ~words[j]);
         chk("external bits", host_bits, ALL_BITS);
         tick(300);
      end
      $display("external clock reads done");
      clock_source_select_i = 1'b0;
      power_down_request_i = 1'b1;
      tick(2);
      chk("low power", low_power_o, 1'b1);
      convert_strobe_n_i = 1'b0;
      tick(5);
      chk("no start in power-down", {sample_hold_o, busy_n_o}, 2'b01);
      power_down_request_i = 1'b0;
      tick(5);
      chk("strobe low across wake", {sample_hold_o, busy_n_o, low_power_o}, 3'b010);
      convert_strobe_n_i = 1'b1;
      tick(2);
      start();
      chk("start after wake", {sample_hold_o, busy_n_o}, 2'b10);
      push(16'h6A6A);
      wait_busy(1000);
      $display("power-down test done");
      convert_strobe_n_i = 1'b1;
      tick(300);
      // reset in the middle of a conversion; strobe is raised so release is no edge
      start();
      tick(100);
      rst_i = 1'b1;
      convert_strobe_n_i = 1'b1;
      tick(2);
      chk("mid-run reset", {busy_n_o, busy_n_oe_o, serial_data_oe_o, serial_bit_clock_oe_o,
          result_ready_o, sample_hold_o, low_power_o}, 7'h44);
      rst_i = 1'b0;
      tick(2);
      chk("after reset", {busy_n_o, busy_n_oe_o, sample_hold_o}, 3'b110);
      $display("mid-run reset done");
      give_verdict();
   end
endmodule : tb_top
